// *** rtl/chan_opt_pkg.sv ***
// Purpose: Shared constants for the serial channel option logic
// Assumes: 8-bit register port, one clock
// Notes: Offsets are byte addresses on the plain register port
package chan_opt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CHANNEL_OPTION_2 = 8'h09;
  localparam logic [7:0] OFS_CHANNEL_OPTION_3 = 8'h0a;
  localparam logic [7:0] OFS_XON_CHAR = 8'h1c;
  localparam logic [7:0] OFS_XOFF_CHAR = 8'h1d;
  localparam logic [7:0] OFS_FLOW_STATUS = 8'h1e;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_XON = 8'h11;
  localparam logic [7:0] RST_XOFF = 8'h13;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ----------------------------------------
  // Field positions in channel_option_2
  // ----------------------------------------
  localparam int BIT_IMPLIED_RESUME = 7;
  localparam int BIT_INBAND_FLOW = 6;
  localparam int BIT_EMBEDDED_CMD = 5;
  localparam int BIT_LOCAL_LOOP = 4;
  localparam int BIT_REMOTE_LOOP = 3;
  localparam int BIT_RTS_AUTO = 2;
  localparam int BIT_CTS_AUTO = 1;
  localparam int BIT_DSR_AUTO = 0;
  // Field in channel_option_3
  localparam int BIT_SCD12_ENABLE = 4;
  // ----------------------------------------
  // Embedded command escape and line levels
  // ----------------------------------------
  localparam logic [7:0] EMB_ESCAPE = 8'h00;
  localparam logic LINE_MARK = 1'b1;
  localparam logic SYNC_RST = 1'b1;
  // ----------------------------------------
  // Flow state
  // ----------------------------------------
  typedef enum logic [0:0] {
    FLOW_RUN = 1'b0,
    FLOW_HELD = 1'b1
  } flow_state_e;
endpackage

// *** rtl/pin_sync.sv ***
// Purpose: Two flip-flop synchroniser for one pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync
  import chan_opt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic pin_s
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = pin;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pin_s = sync_ff;
endmodule

// *** rtl/serial_channel_flow_loopback_control.sv ***
// Purpose: Flow control, embedded commands, loopback and modem gating
// Assumes: Character engine and FIFOs on clk_sys, modem pins asynchronous
// Notes: Active-low modem pins, line idles at mark
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module serial_channel_flow_loopback_control
  import chan_opt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic chan_enable_cmd,
  input wire logic chan_enabled,
  input wire logic rts_manual,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_err,
  output logic rxf_valid,
  output logic [7:0] rxf_data,
  input wire logic txf_valid,
  input wire logic [7:0] txf_data,
  output logic txf_ready,
  output logic hold_valid,
  output logic [7:0] hold_data,
  input wire logic hold_ready,
  input wire logic tx_busy,
  output logic emb_cmd_valid,
  output logic [7:0] emb_cmd_code,
  input wire logic eng_txd,
  output logic eng_rxd,
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic rxd_s;
  logic cts_n_s;
  logic dsr_n_s;

  pin_sync u_rxd (.clk_sys(clk_sys), .rst(rst), .pin(rxd_pin), .pin_s(rxd_s));
  pin_sync u_cts (.clk_sys(clk_sys), .rst(rst), .pin(cts_n), .pin_s(cts_n_s));
  pin_sync u_dsr (.clk_sys(clk_sys), .rst(rst), .pin(dsr_n), .pin_s(dsr_n_s));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] opt2_ff;
  logic [7:0] opt3_ff;
  logic [7:0] xon_ff;
  logic [7:0] xoff_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_opt2;
  logic [7:0] nxt_opt3;
  logic [7:0] nxt_xon;
  logic [7:0] nxt_xoff;
  logic [7:0] nxt_rdata;
  flow_state_e flow_ff;
  flow_state_e nxt_flow;
  logic esc_ff;
  logic nxt_esc;

  always_comb begin
    nxt_opt2 = opt2_ff;
    nxt_opt3 = opt3_ff;
    nxt_xon = xon_ff;
    nxt_xoff = xoff_ff;
    nxt_rdata = RD_UNMAPPED;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CHANNEL_OPTION_2: nxt_opt2 = reg_wdata;
        OFS_CHANNEL_OPTION_3: nxt_opt3 = reg_wdata;
        OFS_XON_CHAR: nxt_xon = reg_wdata;
        OFS_XOFF_CHAR: nxt_xoff = reg_wdata;
        default: nxt_opt2 = opt2_ff;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CHANNEL_OPTION_2: nxt_rdata = opt2_ff;
        OFS_CHANNEL_OPTION_3: nxt_rdata = opt3_ff;
        OFS_XON_CHAR: nxt_rdata = xon_ff;
        OFS_XOFF_CHAR: nxt_rdata = xoff_ff;
        OFS_FLOW_STATUS: nxt_rdata = {5'h00, esc_ff, ~rts_n, flow_ff == FLOW_HELD};
        default: nxt_rdata = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opt2_ff <= RST_OPTION;
      opt3_ff <= RST_OPTION;
      xon_ff <= RST_XON;
      xoff_ff <= RST_XOFF;
      rdata_ff <= RD_UNMAPPED;
    end else begin
      opt2_ff <= nxt_opt2;
      opt3_ff <= nxt_opt3;
      xon_ff <= nxt_xon;
      xoff_ff <= nxt_xoff;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------
  // Option decode
  // ----------------------------------------
  logic implied_resume_mode;
  logic inband_tx_flow_enable;
  logic embedded_tx_command_enable;
  logic local_loopback;
  logic remote_loopback;
  logic rts_auto_output;
  logic cts_auto_enable;
  logic dsr_auto_enable;
  logic scd12_enable;

  assign implied_resume_mode = opt2_ff[BIT_IMPLIED_RESUME];
  assign inband_tx_flow_enable = opt2_ff[BIT_INBAND_FLOW];
  assign embedded_tx_command_enable = opt2_ff[BIT_EMBEDDED_CMD];
  assign local_loopback = opt2_ff[BIT_LOCAL_LOOP];
  assign remote_loopback = opt2_ff[BIT_REMOTE_LOOP];
  assign rts_auto_output = opt2_ff[BIT_RTS_AUTO];
  assign cts_auto_enable = opt2_ff[BIT_CTS_AUTO];
  assign dsr_auto_enable = opt2_ff[BIT_DSR_AUTO];
  assign scd12_enable = opt3_ff[BIT_SCD12_ENABLE];

  // ----------------------------------------
  // In-band transmit flow
  // ----------------------------------------
  logic rx_clean;
  logic flow_cmp;
  logic xoff_hit;
  logic resume_hit;

  assign rx_clean = rx_char_valid && !rx_char_err;
  assign flow_cmp = inband_tx_flow_enable && scd12_enable && rx_clean;
  assign xoff_hit = flow_cmp && rx_char == xoff_ff;
  assign resume_hit = flow_cmp && (rx_char == xon_ff || implied_resume_mode);

  always_comb begin
    nxt_flow = flow_ff;
    unique case (flow_ff)
      FLOW_RUN: if (xoff_hit && !chan_enable_cmd) begin
        nxt_flow = FLOW_HELD;
      end
      FLOW_HELD: if (chan_enable_cmd || (resume_hit && !xoff_hit)) begin
        nxt_flow = FLOW_RUN;
      end
    endcase
    if (!inband_tx_flow_enable && !chan_enable_cmd && flow_ff == FLOW_HELD) begin
      nxt_flow = FLOW_HELD;
    end
  end

  // ----------------------------------------
  // Transmit path with embedded commands
  // ----------------------------------------
  logic tx_gate;
  logic tx_take;
  logic hold_valid_ff;
  logic [7:0] hold_data_ff;
  logic emb_valid_ff;
  logic [7:0] emb_code_ff;
  logic nxt_hold_valid;
  logic [7:0] nxt_hold_data;
  logic nxt_emb_valid;
  logic [7:0] nxt_emb_code;

  // New characters stop here; holding and shift contents still drain
  assign tx_gate = flow_ff == FLOW_RUN && !(cts_auto_enable && cts_n_s);
  assign txf_ready = tx_gate && (!hold_valid_ff || hold_ready);
  assign tx_take = txf_valid && txf_ready;

  always_comb begin
    nxt_hold_valid = hold_valid_ff && !hold_ready;
    nxt_hold_data = hold_data_ff;
    nxt_emb_valid = 1'b0;
    nxt_emb_code = emb_code_ff;
    nxt_esc = esc_ff && embedded_tx_command_enable;
    if (tx_take) begin
      if (embedded_tx_command_enable && esc_ff) begin
        nxt_emb_valid = 1'b1;
        nxt_emb_code = txf_data;
        nxt_esc = 1'b0;
      end else if (embedded_tx_command_enable && txf_data == EMB_ESCAPE) begin
        nxt_esc = 1'b1;
      end else begin
        nxt_hold_valid = 1'b1;
        nxt_hold_data = txf_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flow_ff <= FLOW_RUN;
      esc_ff <= 1'b0;
      hold_valid_ff <= 1'b0;
      hold_data_ff <= RST_OPTION;
      emb_valid_ff <= 1'b0;
      emb_code_ff <= RST_OPTION;
    end else begin
      flow_ff <= nxt_flow;
      esc_ff <= nxt_esc;
      hold_valid_ff <= nxt_hold_valid;
      hold_data_ff <= nxt_hold_data;
      emb_valid_ff <= nxt_emb_valid;
      emb_code_ff <= nxt_emb_code;
    end
  end

  assign hold_valid = hold_valid_ff;
  assign hold_data = hold_data_ff;
  assign emb_cmd_valid = emb_valid_ff;
  assign emb_cmd_code = emb_code_ff;

  // ----------------------------------------
  // Receive delivery, loopback and RTS
  // ----------------------------------------
  logic rxf_valid_ff;
  logic [7:0] rxf_data_ff;
  logic txd_ff;
  logic rts_n_ff;
  logic nxt_rxf_valid;
  logic [7:0] nxt_rxf_data;
  logic nxt_txd;
  logic nxt_rts_n;
  logic tx_pending;

  assign tx_pending = txf_valid || hold_valid_ff || tx_busy;

  always_comb begin
    nxt_rxf_valid = rx_char_valid && !(dsr_auto_enable && dsr_n_s);
    nxt_rxf_data = rx_char_valid ? rx_char : rxf_data_ff;
    if (local_loopback) begin
      nxt_txd = LINE_MARK;
    end else if (remote_loopback) begin
      nxt_txd = rxd_s;
    end else begin
      nxt_txd = eng_txd;
    end
    if (rts_auto_output) begin
      nxt_rts_n = !(chan_enabled && tx_pending);
    end else begin
      nxt_rts_n = !rts_manual;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxf_valid_ff <= 1'b0;
      rxf_data_ff <= RST_OPTION;
      txd_ff <= LINE_MARK;
      rts_n_ff <= 1'b1;
    end else begin
      rxf_valid_ff <= nxt_rxf_valid;
      rxf_data_ff <= nxt_rxf_data;
      txd_ff <= nxt_txd;
      rts_n_ff <= nxt_rts_n;
    end
  end

  assign eng_rxd = local_loopback ? eng_txd : rxd_s;
  assign rxf_valid = rxf_valid_ff;
  assign rxf_data = rxf_data_ff;
  assign txd_pin = txd_ff;
  assign rts_n = rts_n_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  opt_reset_a: assert property (disable iff (1'b0) rst |=> opt2_ff == RST_OPTION)
    else $error("Option register not cleared by reset");
  opt_write_read_a: assert property (reg_wr && reg_addr == OFS_CHANNEL_OPTION_2 ##1
      reg_rd && reg_addr == OFS_CHANNEL_OPTION_2 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Option register readback mismatch");
  xoff_stop_a: assert property (xoff_hit && !chan_enable_cmd |=> !txf_ready)
    else $error("Transmit not stopped after XOFF");
  hold_drain_a: assert property (flow_ff == FLOW_HELD && hold_valid_ff && !hold_ready
      |=> hold_valid_ff)
    else $error("Held character dropped on XOFF");
  xon_resume_a: assert property (flow_ff == FLOW_HELD && resume_hit && !xoff_hit
      |=> flow_ff == FLOW_RUN)
    else $error("Transmit not resumed");
  implied_any_a: assert property (flow_ff == FLOW_HELD && implied_resume_mode
      && flow_cmp && rx_char != xoff_ff |=> flow_ff == FLOW_RUN)
    else $error("Implied resume failed");
  emb_cmd_a: assert property (tx_take && embedded_tx_command_enable && esc_ff
      |=> emb_cmd_valid && emb_cmd_code == $past(txf_data))
    else $error("Embedded command not executed");
  local_loop_a: assert property (local_loopback |-> eng_rxd == eng_txd)
    else $error("Local loopback path broken");
  local_mark_a: assert property (local_loopback |=> txd_pin == LINE_MARK)
    else $error("Transmit pin not marking in local loopback");
  remote_echo_a: assert property (remote_loopback && !local_loopback
      |=> txd_pin == $past(rxd_s))
    else $error("Remote echo mismatch");
  rts_on_a: assert property (rts_auto_output && chan_enabled && txf_valid |=> !rts_n)
    else $error("Auto RTS not asserted");
  rts_off_a: assert property (rts_auto_output && !chan_enabled |=> rts_n)
    else $error("Auto RTS not negated");
  cts_gate_a: assert property (cts_auto_enable && cts_n_s |-> !txf_ready)
    else $error("Transmit started without CTS");
  dsr_drop_a: assert property (dsr_auto_enable && dsr_n_s |=> !rxf_valid)
    else $error("Character delivered without DSR");

  xoff_cycle_c: cover property (xoff_hit ##[1:20] flow_ff == FLOW_RUN);
  emb_cmd_c: cover property (emb_cmd_valid);
  remote_echo_c: cover property (remote_loopback && !rxd_s ##1 !txd_pin);
  rts_cycle_c: cover property (rts_auto_output && !rts_n ##[1:20] rts_n);
endmodule

// *** verification/remote_modem.sv ***
// Purpose: Remote modem or terminal on the line side of the channel
// Assumes: Line idles at mark whenever the far end is not talking
// Notes: Pins change just after the rising edge
`timescale 1ns/1ps
module remote_modem (
  input wire logic clk_sys,
  input wire logic talk,
  input wire logic cts_block,
  input wire logic dsr_off,
  output logic rxd_pin,
  output logic cts_n,
  output logic dsr_n
);
  logic [7:0] pat_ff;
  initial begin
    pat_ff = 8'h5a;
    rxd_pin = 1'b1;
    cts_n = 1'b0;
    dsr_n = 1'b0;
  end
  // ----------------------------------------
  // Line and handshake drive
  // ----------------------------------------
  always @(posedge clk_sys) begin
    pat_ff <= {pat_ff[6:0], pat_ff[7] ^ pat_ff[5] ^ pat_ff[0]};
    rxd_pin <= talk ? pat_ff[0] : 1'b1;
    cts_n <= cts_block;
    dsr_n <= dsr_off;
  end
endmodule

// *** verification/serial_channel_flow_loopback_control_tb_top.sv ***
// Purpose: Self-checking bench for the serial channel option logic
// Assumes: Register reads answer one cycle after the strobe
// Notes: Drivers queue expectations, a falling-edge monitor compares
`timescale 1ns/1ps
module serial_channel_flow_loopback_control_tb_top
  import chan_opt_pkg::*;
;
  logic clk_sys, rst, reg_wr, reg_rd, chan_enable_cmd, chan_enabled, rts_manual;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_char, rxf_data, txf_data, hold_data;
  logic [7:0] emb_cmd_code;
  logic rx_char_valid, rx_char_err, rxf_valid, txf_valid, txf_ready, hold_valid, hold_ready;
  logic tx_busy, emb_cmd_valid, eng_txd, eng_rxd, rxd_pin, txd_pin, cts_n, dsr_n, rts_n;
  logic talk, cts_block, dsr_off, lb_on, rl_on;
  logic rd_flag = 1'b0;
  logic [2:0] hist = 3'h0;
  logic [31:0] seed = 32'h26fe;
  logic [7:0] q_rd[$], q_rx[$], q_tx[$], q_cmd[$];
  int n_fail = 0;
  int checks_done = 0;

  serial_channel_flow_loopback_control uut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan_enable_cmd(chan_enable_cmd), .chan_enabled(chan_enabled),
    .rts_manual(rts_manual), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_char_err(rx_char_err), .rxf_valid(rxf_valid), .rxf_data(rxf_data),
    .txf_valid(txf_valid), .txf_data(txf_data), .txf_ready(txf_ready),
    .hold_valid(hold_valid), .hold_data(hold_data), .hold_ready(hold_ready),
    .tx_busy(tx_busy), .emb_cmd_valid(emb_cmd_valid), .emb_cmd_code(emb_cmd_code),
    .eng_txd(eng_txd), .eng_rxd(eng_rxd), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n));

  remote_modem modem (.clk_sys(clk_sys), .talk(talk), .cts_block(cts_block),
    .dsr_off(dsr_off), .rxd_pin(rxd_pin), .cts_n(cts_n), .dsr_n(dsr_n));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    q_rd.push_back(d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic rx(input logic [7:0] d, input logic err, input logic keep);
    if (keep) q_rx.push_back(d);
    @(posedge clk_sys);
    rx_char_valid <= 1'b1;
    rx_char <= d;
    rx_char_err <= err;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
  endtask
  task automatic tx_offer(input logic [7:0] d);
    @(posedge clk_sys);
    txf_valid <= 1'b1;
    txf_data <= d;
  endtask
  task automatic tx_take();
    int i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (!txf_ready && i < 64);
    chk("txf_taken", 8'h01, {7'h0, txf_ready});
    @(posedge clk_sys);
    txf_valid <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] d);
    tx_offer(d);
    tx_take();
  endtask
  task automatic stalled(input logic [7:0] d);
    tx_offer(d);
    repeat (4) @(negedge clk_sys);
    chk("txf_ready", 8'h00, {7'h0, txf_ready});
  endtask
  // ----------------------------------------
  // Random drive and monitor
  // ----------------------------------------
  always @(posedge clk_sys) begin
    seed <= lfsr(seed);
    hold_ready <= seed[3] | seed[9];
    eng_txd <= seed[5];
  end
  always @(negedge clk_sys) begin
    if (rd_flag) chk("reg_rdata", q_rd.size() ? q_rd.pop_front() : 8'hxx, reg_rdata);
    rd_flag = reg_rd;
    if (rxf_valid) chk("rxf_data", q_rx.size() ? q_rx.pop_front() : 8'hxx, rxf_data);
    if (hold_valid && hold_ready) begin
      chk("hold_data", q_tx.size() ? q_tx.pop_front() : 8'hxx, hold_data);
    end
    if (emb_cmd_valid) chk("cmd", q_cmd.size() ? q_cmd.pop_front() : 8'hxx, emb_cmd_code);
    if (lb_on) begin
      chk("txd_pin", 8'h01, {7'h0, txd_pin});
      chk("eng_rxd", {7'h0, eng_txd}, {7'h0, eng_rxd});
    end
    if (rl_on) chk("txd_echo", {7'h0, hist[2]}, {7'h0, txd_pin});
    hist = {hist[1:0], rxd_pin};
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    {reg_addr, reg_wdata, rx_char, txf_data} = 32'h0;
    {reg_wr, reg_rd, chan_enable_cmd, chan_enabled, rts_manual, rx_char_valid} = 6'h0;
    {rx_char_err, txf_valid, tx_busy} = 3'h0;
    {talk, cts_block, dsr_off, lb_on, rl_on} = 5'h0;
    rst = SYNC_RST;
    repeat (2) @(posedge clk_sys);
    rst <= ~SYNC_RST;
    rd(OFS_CHANNEL_OPTION_2, RST_OPTION);
    rd(OFS_XON_CHAR, RST_XON);
    rd(OFS_XOFF_CHAR, RST_XOFF);
    rd(8'h55, RD_UNMAPPED);
    r = seed[7:0];
    wr_rd(OFS_CHANNEL_OPTION_2, r);
    wr(8'h55, ~r);
    rd(OFS_CHANNEL_OPTION_2, r);
    $display("test registers done");
    wr(OFS_CHANNEL_OPTION_2, 8'h01);
    for (int i = 0; i < 3; i++) rx(seed[7:0], seed[8], 1'b1);
    dsr_off <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rx(8'h3d, 1'b0, 1'b0);
    dsr_off <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rx(8'h3e, 1'b0, 1'b1);
    $display("test receive done");
    wr(OFS_CHANNEL_OPTION_3, 8'h10);
    rd(OFS_CHANNEL_OPTION_3, 8'h10);
    wr(OFS_CHANNEL_OPTION_2, 8'h40);
    rx(RST_XOFF, 1'b1, 1'b1);
    rd(OFS_FLOW_STATUS, 8'h00);
    rx(RST_XOFF, 1'b0, 1'b1);
    rd(OFS_FLOW_STATUS, 8'h01);
    stalled(8'h5b);
    rx(8'ha7, 1'b0, 1'b1);
    rd(OFS_FLOW_STATUS, 8'h01);
    rx(RST_XON, 1'b0, 1'b1);
    q_tx.push_back(8'h5b);
    tx_take();
    wr(OFS_CHANNEL_OPTION_2, 8'hc0);
    rx(RST_XOFF, 1'b0, 1'b1);
    rx(RST_XOFF, 1'b0, 1'b1);
    rd(OFS_FLOW_STATUS, 8'h01);
    rx(8'h42, 1'b0, 1'b1);
    rd(OFS_FLOW_STATUS, 8'h00);
    rx(RST_XOFF, 1'b0, 1'b1);
    @(posedge clk_sys);
    chan_enable_cmd <= 1'b1;
    @(posedge clk_sys);
    chan_enable_cmd <= 1'b0;
    rd(OFS_FLOW_STATUS, 8'h00);
    $display("test flow done");
    wr(OFS_CHANNEL_OPTION_2, 8'h20);
    q_cmd.push_back(8'h81);
    q_tx.push_back(8'h66);
    tx(EMB_ESCAPE);
    tx(8'h81);
    tx(8'h66);
    wr(OFS_CHANNEL_OPTION_2, 8'h02);
    cts_block <= 1'b1;
    repeat (4) @(posedge clk_sys);
    stalled(8'h77);
    cts_block <= 1'b0;
    q_tx.push_back(8'h77);
    tx_take();
    $display("test transmit done");
    talk <= 1'b1;
    wr(OFS_CHANNEL_OPTION_2, 8'h10);
    repeat (2) @(posedge clk_sys);
    lb_on <= 1'b1;
    repeat (20) @(posedge clk_sys);
    wr(OFS_CHANNEL_OPTION_2, 8'h18);
    repeat (20) @(posedge clk_sys);
    lb_on <= 1'b0;
    wr(OFS_CHANNEL_OPTION_2, 8'h08);
    repeat (4) @(posedge clk_sys);
    rl_on <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rl_on <= 1'b0;
    talk <= 1'b0;
    $display("test loopback done");
    wr(OFS_CHANNEL_OPTION_2, 8'h04);
    chan_enabled <= 1'b1;
    tx_busy <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("rts_n", 8'h00, {7'h0, rts_n});
    @(posedge clk_sys);
    tx_busy <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("rts_n", 8'h01, {7'h0, rts_n});
    @(posedge clk_sys);
    tx_busy <= 1'b1;
    chan_enabled <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("rts_n", 8'h01, {7'h0, rts_n});
    wr(OFS_CHANNEL_OPTION_2, 8'h00);
    rts_manual <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("rts_n", 8'h00, {7'h0, rts_n});
    $display("test rts done");
    repeat (20) @(posedge clk_sys);
    chk("queues", 8'h00, 8'(q_rd.size() + q_rx.size() + q_tx.size() + q_cmd.size()));
    wrap_up();
  end
endmodule
